// File: ppf_pkg.sv
package ppf_pkg;
    // register map, byte offsets on the host port
    localparam logic [7:0] PPF_PIN_FOUR_ADDR = 8'h44;
    localparam logic [7:0] PPF_PIN_FIVE_ADDR = 8'h45;
    // field positions inside each control register
    localparam int PPF_BIT_OUT_VALUE = 0;
    localparam int PPF_BIT_PAD_LEVEL = 1;
    localparam int PPF_BIT_DIRECTION = 2;
    localparam int PPF_BIT_PULLDOWN = 3;
    localparam int PPF_BIT_DEBOUNCE = 4;
    localparam int PPF_BIT_OPEN_DRAIN = 5;
    localparam int PPF_BIT_SOURCE = 6;
    localparam int PPF_BIT_SLEEP_LOW = 7;
    // writable bits: everything but the pad level
    localparam logic [7:0] PPF_WR_MASK = 8'hfd;
    // debounce filter times and their cycle counts at 200 MHz
    localparam int PPF_CLK_MHZ = 200;
    localparam int PPF_DEB_SHORT_US = 94;
    localparam int PPF_DEB_LONG_US = 156;
    localparam int PPF_DEB_SHORT_CYC = PPF_DEB_SHORT_US * PPF_CLK_MHZ;
    localparam int PPF_DEB_LONG_CYC = PPF_DEB_LONG_US * PPF_CLK_MHZ;
    localparam int PPF_CNT_W = 16;
endpackage : ppf_pkg

// File: ppf_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppf_filt_if;
    logic raw;
    logic long_sel;
    logic level;
    modport ctrl (output raw, output long_sel, input level);
    modport filt (input raw, input long_sel, output level);
endinterface : ppf_filt_if
`default_nettype wire

// File: ppf_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_debounce
    import ppf_pkg::*;
#(
    parameter int SHORT_CYC = PPF_DEB_SHORT_CYC,
    parameter int LONG_CYC = PPF_DEB_LONG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // filter channel
    ppf_filt_if.filt fi
);
    logic [PPF_CNT_W-1:0] cnt_q, cnt_d, limit;
    logic level_q, level_d;

    assign fi.level = level_q;

    always_comb begin
        limit = fi.long_sel ? PPF_CNT_W'(LONG_CYC - 1)
                            : PPF_CNT_W'(SHORT_CYC - 1);
        cnt_d = cnt_q;
        level_d = level_q;
        // any bounce restarts the window
        if (fi.raw == level_q) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            level_d = fi.raw;
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            level_q <= level_d;
        end
    end
endmodule : ppf_debounce
`default_nettype wire

// File: ppf_pin_port.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ppf_pin_port
    import ppf_pkg::*;
#(
    parameter int SHORT_CYC = PPF_DEB_SHORT_CYC,
    parameter int LONG_CYC = PPF_DEB_LONG_CYC
) (
    // clock, power-on reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // defaults from one-time memory
    input wire logic [7:0] otp_four,
    input wire logic [7:0] otp_five,
    input wire logic otp_load,
    // host register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // device state and led channels
    input wire logic sleep_state,
    input wire logic second_led_channel,
    input wire logic third_led_channel,
    // pads
    input wire logic pad_four_in,
    output logic pad_four_out,
    output logic pad_four_oe_n,
    output logic pad_four_pulldown,
    output logic pad_four_seq_ctl,
    input wire logic pad_five_in,
    output logic pad_five_out,
    output logic pad_five_oe_n,
    output logic pad_five_pulldown,
    output logic pad_five_seq_ctl
);
    logic [7:0] ctl_q [2];
    logic [7:0] ctl_d [2];
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] out_q, out_d, oen_q, oen_d, pd_q, pd_d, seq_q, seq_d;
    logic [1:0] pad_in, led_src, level;
    logic [1:0] sel;

    ppf_filt_if fi [2] ();

    assign pad_in = {pad_five_in, pad_four_in};
    assign led_src = {third_led_channel, second_led_channel};
    assign sel[0] = (reg_addr == PPF_PIN_FOUR_ADDR);
    assign sel[1] = (reg_addr == PPF_PIN_FIVE_ADDR);

    for (genvar i = 0; i < 2; i++) begin : g_pin
        assign fi[i].raw = pad_in[i];
        assign fi[i].long_sel = ctl_q[i][PPF_BIT_DEBOUNCE];
        assign level[i] = fi[i].level;
        ppf_debounce #(
            .SHORT_CYC(SHORT_CYC),
            .LONG_CYC(LONG_CYC)
        ) u_deb (
            .clk(clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .fi(fi[i])
        );
    end

    // register file and read port
    always_comb begin
        rdata_d = 8'h00;
        for (int i = 0; i < 2; i++) begin
            ctl_d[i] = ctl_q[i];
            if (otp_load) begin
                ctl_d[i] = (i == 0 ? otp_four : otp_five) & PPF_WR_MASK;
            end else if (reg_wr && sel[i]) begin
                ctl_d[i] = reg_wdata & PPF_WR_MASK;
            end
            if (reg_rd && sel[i]) begin
                rdata_d = ctl_q[i];
                rdata_d[PPF_BIT_PAD_LEVEL] = level[i];
            end
        end
    end

    // pad drive, all registered so pins never glitch
    always_comb begin
        logic val;
        logic is_out;
        val = 1'b0;
        is_out = 1'b0;
        out_d = 2'h0;
        oen_d = 2'h3;
        pd_d = 2'h0;
        seq_d = 2'h0;
        for (int i = 0; i < 2; i++) begin
            is_out = ctl_q[i][PPF_BIT_DIRECTION];
            if (ctl_q[i][PPF_BIT_SOURCE]) begin
                val = led_src[i];
            end else begin
                val = ctl_q[i][PPF_BIT_OUT_VALUE];
            end
            if (ctl_q[i][PPF_BIT_SLEEP_LOW] && sleep_state) begin
                val = 1'b0;
            end
            out_d[i] = val;
            if (!is_out) begin
                oen_d[i] = 1'b1;
            end else if (ctl_q[i][PPF_BIT_OPEN_DRAIN]) begin
                oen_d[i] = val; // release for high
            end else begin
                oen_d[i] = 1'b0;
            end
            pd_d[i] = ctl_q[i][PPF_BIT_PULLDOWN];
            seq_d[i] = is_out && !ctl_q[i][PPF_BIT_OPEN_DRAIN];
        end
    end

    // power-on reset clears these; rdata_q also clears on every enabled cycle without a matching read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q[0] <= 8'h00;
            ctl_q[1] <= 8'h00;
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            ctl_q[0] <= ctl_d[0];
            ctl_q[1] <= ctl_d[1];
            rdata_q <= rdata_d;
        end
    end

    // pads come out of reset released, nothing driven
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 2'h0;
            oen_q <= 2'h3;
            pd_q <= 2'h0;
            seq_q <= 2'h0;
        end else if (clk_en) begin
            out_q <= out_d;
            oen_q <= oen_d;
            pd_q <= pd_d;
            seq_q <= seq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign pad_four_out = out_q[0];
    assign pad_five_out = out_q[1];
    assign pad_four_oe_n = oen_q[0];
    assign pad_five_oe_n = oen_q[1];
    assign pad_four_pulldown = pd_q[0];
    assign pad_five_pulldown = pd_q[1];
    assign pad_four_seq_ctl = seq_q[0];
    assign pad_five_seq_ctl = seq_q[1];
endmodule : ppf_pin_port
`default_nettype wire

// File: ppf_board.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_board (
    // device pad side
    input wire logic out,
    input wire logic oe_n,
    input wire logic pd,
    // board driver
    input wire logic ext_en,
    input wire logic ext_v,
    output logic pad
);
    // board pull-up loses to the pad pulldown
    assign pad = !oe_n ? out : ext_en ? ext_v : !pd;
endmodule : ppf_board
`default_nettype wire

// File: ppf_pin_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_pin_port_chk
    import ppf_pkg::*;
(
    // clock, reset, host port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic otp_load,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // pads
    input wire logic pad_four_out,
    input wire logic pad_four_oe_n,
    input wire logic pad_four_seq_ctl,
    input wire logic pad_five_out,
    input wire logic pad_five_oe_n,
    input wire logic pad_five_seq_ctl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr4;
        clk_en && reg_wr && reg_addr == PPF_PIN_FOUR_ADDR;
    endsequence
    sequence rd4;
        clk_en && reg_rd && reg_addr == PPF_PIN_FOUR_ADDR && !otp_load;
    endsequence
    od_four_a: assert property (!pad_four_oe_n && !pad_four_seq_ctl
        |-> !pad_four_out) else $error("od4 high");
    od_five_a: assert property (!pad_five_oe_n && !pad_five_seq_ctl
        |-> !pad_five_out) else $error("od5 high");
    pp_four_a: assert property (pad_four_seq_ctl |-> !pad_four_oe_n)
        else $error("pp4 undriven");
    pp_five_a: assert property (pad_five_seq_ctl |-> !pad_five_oe_n)
        else $error("pp5 undriven");
    // a frozen cycle holds the old read data, so it is left out
    rd_idle_a: assert property ($past(clk_en) && !$past(reg_rd)
        |-> reg_rdata == 8'h00) else $error("rdata not idle");
    rd_unmap_a: assert property ($past(clk_en) && $past(reg_rd) &&
        $past(reg_addr) > PPF_PIN_FIVE_ADDR |-> reg_rdata == 8'h00)
        else $error("unmap");
    por_pads_a: assert property ($rose(rst_n)
        |-> pad_four_oe_n && pad_five_oe_n) else $error("pads after reset");
    read_back_a: assert property (wr4 ##2 rd4 |=>
        (reg_rdata & PPF_WR_MASK) == ($past(reg_wdata, 3) & PPF_WR_MASK))
        else $error("readback");
endmodule : ppf_pin_port_chk
bind ppf_pin_port ppf_pin_port_chk u_ppf_pin_port_chk (.clk, .rst_n,
    .clk_en, .otp_load, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .pad_four_out, .pad_four_oe_n, .pad_four_seq_ctl, .pad_five_out,
    .pad_five_oe_n, .pad_five_seq_ctl);
`default_nettype wire

// File: ppf_pin_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_pin_port_tb;
    typedef struct packed {
        logic [7:0] c;
        logic l, s;
        logic [3:0] e4, e5;
    } ppf_row_t;
    // config, led, sleep, per pin {out if driven, oe_n, pulldown, seq}
    ppf_row_t rows [10] = '{'{8'h05, 1'b0, 1'b0, 4'h9, 4'h9},
        '{8'h04, 1'b0, 1'b0, 4'h1, 4'h1},
        '{8'h08, 1'b0, 1'b0, 4'h6, 4'h6},
        '{8'h25, 1'b0, 1'b0, 4'h4, 4'h4},
        '{8'h24, 1'b0, 1'b0, 4'h0, 4'h0},
        '{8'h44, 1'b1, 1'b0, 4'h9, 4'h1},
        '{8'h45, 1'b0, 1'b0, 4'h1, 4'h9},
        '{8'h85, 1'b0, 1'b1, 4'h1, 4'h1},
        '{8'hc4, 1'b1, 1'b1, 4'h1, 4'h1},
        '{8'h85, 1'b0, 1'b0, 4'h9, 4'h9}};
    logic clk = 0, rst_n = 0, ld = 0, wr = 0, rd = 0, led = 0, slp = 0;
    logic ce = 1, ee = 0, ev = 0, i4, i5, o4, e4_n, d4, s4, o5, e5_n, d5, s5;
    logic [7:0] a = 0, wd = 0, rdat;
    int fail_count = 0, num_checks = 0;
    wire logic [7:0] p4 = {4'h0, o4 & ~e4_n, e4_n, d4, s4};
    wire logic [7:0] p5 = {4'h0, o5 & ~e5_n, e5_n, d5, s5};
    // channel three runs inverted so a swap of the two sources shows
    ppf_pin_port #(.SHORT_CYC(8), .LONG_CYC(12)) u_ppf_pin_port (.clk,
        .rst_n, .clk_en(ce), .otp_four(8'h0b), .otp_five(8'h1e),
        .otp_load(ld), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .sleep_state(slp),
        .second_led_channel(led), .third_led_channel(~led),
        .pad_four_in(i4), .pad_four_out(o4), .pad_four_oe_n(e4_n),
        .pad_four_pulldown(d4), .pad_four_seq_ctl(s4), .pad_five_in(i5),
        .pad_five_out(o5), .pad_five_oe_n(e5_n), .pad_five_pulldown(d5),
        .pad_five_seq_ctl(s5));
    ppf_board u_ppf_board (.out(o4), .oe_n(e4_n), .pd(d4), .ext_en(ee),
        .ext_v(ev), .pad(i4));
    // pin five has no board driver, only the pull-up
    assign i5 = !e5_n ? o5 : !d5;
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [7:0] s, e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] ad, d);
        @(posedge clk);
        {a, wd, wr} <= {ad, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt
    task automatic rdc(input logic [7:0] ad, e);
        @(posedge clk);
        {a, rd} <= {ad, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdat, e);
    endtask : rdc
    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        {rst_n, ld} <= 2'b11;
        @(posedge clk);
        ld <= 1'b0;
        rdc(8'h44, 8'h09);
        rdc(8'h45, 8'h1c);
        foreach (rows[i]) begin
            wrt(8'h44, rows[i].c);
            wrt(8'h45, rows[i].c);
            {led, slp} <= {rows[i].l, rows[i].s};
            repeat (3) @(posedge clk);
            #1 chk("pin4", p4, rows[i].e4);
            chk("pin5", p5, rows[i].e5);
        end
        @(posedge clk);
        ee <= 1'b1;
        wrt(8'h44, 8'h02);
        repeat (20) @(posedge clk);
        rdc(8'h44, 8'h00);
        // a bounce must restart the filter count
        @(posedge clk);
        ev <= 1'b1;
        repeat (4) @(posedge clk);
        ev <= 1'b0;
        @(posedge clk);
        ev <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(8'h44, 8'h00);
        repeat (8) @(posedge clk);
        rdc(8'h44, 8'h02);
        @(posedge clk);
        ev <= 1'b0;
        wrt(8'h44, 8'h10);
        rdc(8'h44, 8'h12);
        repeat (4) @(posedge clk);
        rdc(8'h44, 8'h12);
        repeat (8) @(posedge clk);
        rdc(8'h44, 8'h10);
        wrt(8'h46, 8'hff);
        rdc(8'h46, 8'h00);
        rdc(8'h44, 8'h10);
        // with the enable low a write must not land
        @(posedge clk);
        ce <= 1'b0;
        wrt(8'h45, 8'h00);
        ce <= 1'b1;
        rdc(8'h45, 8'h87);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h44, 8'h00);
        rdc(8'h45, 8'h00);
        final_report();
    end
endmodule : ppf_pin_port_tb
`default_nettype wire
